//--- hdl/pss_burst_seq.v
`timescale 1ns/1ns
`default_nettype none
`include "pss_consts.vh"
// Burst address generator: loaded value plus step count (linear) or XOR step count (interleaved)
module pss_burst_seq
(
    input wire clk,
    input wire srst,
    input wire input_gate,
    input wire load,
    input wire advance,
    input wire interleave,
    input wire [1:0] start_lsbs,
    output wire [1:0] burst_lsbs_now
);
    reg [1:0] base_reg;
    reg [1:0] step_reg;

    ////////////////////////////////////////////////////////////////
    // Counter holds still while input_gate is high
    always @(posedge clk)
    begin
        if (srst)
        begin
            base_reg <= 2'h0;
            step_reg <= 2'h0;
        end
        else if (!input_gate)
        begin
            if (load)
            begin
                // The load cycle uses the external word itself, so the
                // first advance must already present the second one
                base_reg <= start_lsbs;
                step_reg <= 2'h1;
            end
            else if (advance)
                step_reg <= step_reg + 2'h1;
        end
    end

    // Linear wraps modulo four; interleaved flips bits
    assign burst_lsbs_now = interleave ? (base_reg ^ step_reg) : (base_reg + step_reg);
endmodule
`default_nettype wire

//--- hdl/pss_consts.vh
`ifndef PSS_CONSTS_VH
`define PSS_CONSTS_VH
`define PSS_OP_DESEL 2'h0
`define PSS_OP_READ 2'h1
`define PSS_OP_WRITE 2'h2
`define PSS_BW_IDLE 2'h3
`define PSS_LANE_W 9
`define PSS_ADDR_W 19
`define PSS_BURST_W 2
`endif

//--- hdl/pss_sram_port.v
`timescale 1ns/1ns
`default_nettype none
`include "pss_consts.vh"
// Pipelined synchronous SRAM port, two 9-bit byte lanes
module pss_sram_port
#(
    parameter ADDR_W = `PSS_ADDR_W,
    parameter LANE_W = `PSS_LANE_W
)
(
    input wire clk,
    input wire srst,
    input wire input_gate,
    input wire load_advance,
    input wire [ADDR_W-1:0] address_inputs,
    input wire write_select_n,
    input wire [1:0] byte_write_n,
    input wire primary_enable_n,
    input wire depth_enable_hi,
    input wire depth_enable_lo_n,
    input wire burst_order_pin,
    input wire drive_enable_n,
    input wire [2*LANE_W-1:0] data_lanes_in,
    output wire [2*LANE_W-1:0] data_lanes_out,
    output wire [2*LANE_W-1:0] data_lanes_oe
);
    localparam DEPTH = 1 << ADDR_W;
    localparam DW = 2 * LANE_W;

    // Timing of one access, counted from the edge that samples its load:
    // that edge fills stage two, the next ungated edge registers read data
    // or moves a write into stage three, and the one after that samples
    // the write data. Read data and write data thus share one bus cycle,
    // so reads and writes mix back to back with no idle cycle between.
    // The price: the controller must present write data in exactly that
    // cycle, and a gated edge stretches every stage alike.
    // Deselected cycles flow down the pipe as well and leave lanes idle.

    reg [LANE_W-1:0] mem_a [0:DEPTH-1];
    reg [LANE_W-1:0] mem_b [0:DEPTH-1];

    // Stage one: operation and upper address of the running burst
    reg [1:0] op_reg;
    reg [ADDR_W-1:2] hi_addr_reg;
    // Stage two: address phase done, data phase now
    reg [1:0] d_op_reg;
    reg [ADDR_W-1:0] d_addr_reg;
    reg [1:0] d_bw_reg;
    // Stage three: write data lands, read data registered
    reg [1:0] w_op_reg;
    reg [ADDR_W-1:0] w_addr_reg;
    reg [1:0] w_bw_reg;
    reg [DW-1:0] rd_data_reg;
    reg rd_valid_reg;

    wire chip_en;
    wire load;
    wire advance;
    wire [1:0] lsbs_now;
    // Current cycle, after the load or advance decision
    reg [1:0] cyc_op;
    reg [ADDR_W-1:0] cyc_addr;
    reg [1:0] cyc_bw;
    // Read word and write strobes
    wire [DW-1:0] rd_word;
    wire wr_now;
    wire wr_lane_a;
    wire wr_lane_b;

    ////////////////////////////////////////////////////////////////
    // Enable decode: any one disagreeing enable deselects the chip
    function sel_true;
        input pe_n;
        input de_hi;
        input de_lo_n;
        begin
            sel_true = !pe_n && de_hi && !de_lo_n;
        end
    endfunction

    // Operation named by a load cycle
    function [1:0] load_op;
        input sel;
        input wr_n;
        begin
            if (!sel)
                load_op = `PSS_OP_DESEL;
            else if (wr_n)
                load_op = `PSS_OP_READ;
            else
                load_op = `PSS_OP_WRITE;
        end
    endfunction

    // Stage test shared by the byte enable, read and write paths
    function op_is;
        input [1:0] op;
        input [1:0] kind;
        begin
            op_is = (op == kind);
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // Chip selected only when all three enables agree
    assign chip_en = sel_true(primary_enable_n, depth_enable_hi, depth_enable_lo_n);
    assign load = !load_advance;
    // Advance from a deselect leaves the counter alone
    assign advance = load_advance && !op_is(op_reg, `PSS_OP_DESEL);

    pss_burst_seq u_seq
    (
        .clk(clk),
        .srst(srst),
        .input_gate(input_gate),
        .load(load && chip_en),
        .advance(advance),
        .interleave(burst_order_pin),
        .start_lsbs(address_inputs[1:0]),
        .burst_lsbs_now(lsbs_now)
    );

    // Operation of the current cycle; advance repeats the last one and
    // looks only at the gate, the byte enables, the burst order pin and load_advance
    always @*
    begin
        cyc_op = `PSS_OP_DESEL;
        cyc_addr = address_inputs;
        cyc_bw = `PSS_BW_IDLE;
        case (load_advance)
            1'b0:
            begin
                cyc_op = load_op(chip_en, write_select_n);
                cyc_addr = address_inputs;
            end
            1'b1:
            begin
                cyc_op = op_reg;
                cyc_addr = {hi_addr_reg, lsbs_now};
            end
            default:
            begin
                cyc_op = `PSS_OP_DESEL;
                cyc_addr = address_inputs;
            end
        endcase
        // Byte enables matter only for writes; reads leave them unseen
        if (op_is(cyc_op, `PSS_OP_WRITE))
            cyc_bw = byte_write_n;
    end

    ////////////////////////////////////////////////////////////////
    // Command capture: operation of the cycle and upper burst address
    always @(posedge clk)
    begin
        if (srst)
        begin
            op_reg <= `PSS_OP_DESEL;
            hi_addr_reg <= {(ADDR_W-2){1'b0}};
        end
        else if (!input_gate)
        begin
            op_reg <= cyc_op;
            if (load && chip_en)
                hi_addr_reg <= address_inputs[ADDR_W-1:2];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Pipeline: write data follows its address by two cycles
    always @(posedge clk)
    begin
        if (srst)
        begin
            d_op_reg <= `PSS_OP_DESEL;
            d_addr_reg <= {ADDR_W{1'b0}};
            d_bw_reg <= `PSS_BW_IDLE;
            w_op_reg <= `PSS_OP_DESEL;
            w_addr_reg <= {ADDR_W{1'b0}};
            w_bw_reg <= `PSS_BW_IDLE;
            rd_valid_reg <= 1'b0;
            rd_data_reg <= {DW{1'b0}};
        end
        else if (!input_gate)
        begin
            d_op_reg <= cyc_op;
            d_addr_reg <= cyc_addr;
            d_bw_reg <= cyc_bw;
            w_op_reg <= d_op_reg;
            w_addr_reg <= d_addr_reg;
            w_bw_reg <= d_bw_reg;
            // Read word lands in the output register a cycle later
            rd_valid_reg <= op_is(d_op_reg, `PSS_OP_READ);
            if (op_is(d_op_reg, `PSS_OP_READ))
                rd_data_reg <= rd_word;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Lane strobes: a lane is written only with the write select seen
    // at load and its own byte enable low; a gated edge writes nothing
    assign wr_now = !input_gate && op_is(w_op_reg, `PSS_OP_WRITE);
    assign wr_lane_a = wr_now && !w_bw_reg[0];
    assign wr_lane_b = wr_now && !w_bw_reg[1];

    // Array write; data lanes are sampled on this edge, two after the
    // address, so reads and writes need no idle cycle between them
    always @(posedge clk)
    begin
        if (wr_lane_a)
            mem_a[w_addr_reg] <= data_lanes_in[LANE_W-1:0];
        if (wr_lane_b)
            mem_b[w_addr_reg] <= data_lanes_in[DW-1:LANE_W];
    end

    // Both lanes are read together as one word
    assign rd_word = {mem_b[d_addr_reg], mem_a[d_addr_reg]};

    // Drivers gated without the clock by the output enable
    assign data_lanes_out = rd_data_reg;
    assign data_lanes_oe = {DW{rd_valid_reg && !drive_enable_n}};
endmodule
`default_nettype wire

//--- verif/pss_chk.sv
`timescale 1ns/1ns
`default_nettype none
module pss_chk #(parameter ADDR_W = 6, parameter LANE_W = 9)
(
    input wire clk,
    input wire srst,
    input wire input_gate,
    input wire load_advance,
    input wire [ADDR_W-1:0] address_inputs,
    input wire write_select_n,
    input wire [1:0] byte_write_n,
    input wire primary_enable_n,
    input wire depth_enable_hi,
    input wire depth_enable_lo_n,
    input wire burst_order_pin,
    input wire drive_enable_n,
    input wire [2*LANE_W-1:0] data_lanes_in,
    input wire [2*LANE_W-1:0] data_lanes_out,
    input wire [2*LANE_W-1:0] data_lanes_oe
);
    // Chip selected only when all three enables agree
    wire en = !primary_enable_n && depth_enable_hi && !depth_enable_lo_n;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Load kinds and advance; read data shows after one more ungated edge
    sequence s_rd; !input_gate && !load_advance && en && write_select_n; endsequence
    sequence s_wr; !input_gate && !load_advance && en && !write_select_n; endsequence
    sequence s_ds; !input_gate && !load_advance && !en; endsequence
    sequence s_adv; !input_gate && load_advance; endsequence
    a_oe_async: assert property (drive_enable_n |-> data_lanes_oe == 0) else $error("oe while disabled");
    a_read_drive: assert property (s_rd ##1 !input_gate ##1 !drive_enable_n |-> &data_lanes_oe) else $error("read not driven");
    a_write_hiz: assert property (s_wr ##1 !input_gate |=> data_lanes_oe == 0) else $error("write drove lanes");
    a_desel_idle: assert property (s_ds ##1 !input_gate |=> data_lanes_oe == 0) else $error("deselect drove lanes");
    a_burst_read: assert property (s_rd ##1 s_adv ##1 !input_gate ##1 !drive_enable_n |-> &data_lanes_oe) else $error("burst read lost");
    a_burst_write: assert property (s_wr ##1 s_adv ##1 !input_gate |=> data_lanes_oe == 0) else $error("burst write drove");
    a_burst_desel: assert property (s_ds ##1 s_adv ##1 !input_gate |=> data_lanes_oe == 0) else $error("deselect not kept");
    a_gate_hold: assert property (input_gate |=> $stable(data_lanes_out)) else $error("gated edge moved output");
endmodule
bind pss_sram_port pss_chk #(.ADDR_W(ADDR_W), .LANE_W(LANE_W)) u_chk (.*);
`default_nettype wire

//--- verif/pss_ctl_model.sv
`timescale 1ns/1ns
`default_nettype none
module pss_ctl_model
(
    input wire logic clk,
    output logic input_gate,
    output logic load_advance,
    output logic [5:0] address_inputs,
    output logic write_select_n,
    output logic [1:0] byte_write_n,
    output logic [2:0] ena,
    output logic [17:0] data_lanes_in
);
    // Idle as a deselected load so nothing is written before the first cycle
    initial
    begin
        {input_gate, load_advance, address_inputs, write_select_n, byte_write_n, ena, data_lanes_in} = 32'h00f80000;
    end
    // One controller cycle; address low bits are the burst start word
    task c(input logic g, input logic a, input logic [5:0] ad, input logic w, input logic [1:0] b,
        input logic [2:0] e, input logic [17:0] d);
        @(posedge clk);
        #1;
        {input_gate, load_advance, address_inputs, write_select_n, byte_write_n, ena, data_lanes_in} = {g, a, ad, w, b, e, d};
    endtask
endmodule
`default_nettype wire

//--- verif/tb_pss_sram_port.sv
`timescale 1ns/1ns
`default_nettype none
module tb_pss_sram_port;
    localparam logic [2:0] EN = 3'h2;
    logic clk, srst, ord, de;
    wire g, la, wn;
    wire [5:0] ad;
    wire [1:0] bw;
    wire [2:0] ena;
    wire [17:0] din, dout, doe;
    logic [17:0] exp_mem [0:63];
    int err_count, cmp_count;
    pss_ctl_model u_ctl (.clk(clk), .input_gate(g), .load_advance(la), .address_inputs(ad), .write_select_n(wn),
        .byte_write_n(bw), .ena(ena), .data_lanes_in(din));
    pss_sram_port #(.ADDR_W(6)) DUT (.clk(clk), .srst(srst), .input_gate(g), .load_advance(la), .address_inputs(ad),
        .write_select_n(wn), .byte_write_n(bw), .primary_enable_n(ena[2]), .depth_enable_hi(ena[1]),
        .depth_enable_lo_n(ena[0]), .burst_order_pin(ord), .drive_enable_n(de), .data_lanes_in(din),
        .data_lanes_out(dout), .data_lanes_oe(doe));
    // 100 MHz clock
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task chk(input string n, input logic [17:0] x, input logic [17:0] s);
        cmp_count++;
        if (s !== x)
        begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, x, s);
        end
    endtask
    // Order strap only moves under reset, never in operation
    task rst(input logic o);
        @(posedge clk);
        #1;
        srst = 1;
        ord = o;
        repeat (2) @(posedge clk);
        #1;
        srst = 0;
    endtask
    // Load plus three advances, then three deselects to drain the pipe
    task burst(input logic w, input logic [5:0] a, input logic [1:0] b, input logic [17:0] d, input logic [2:0] e);
        logic [5:0] q [0:3];
        logic on;
        logic [17:0] dk;
        on = (e == EN);
        for (int k = 0; k < 4; k++)
            q[k] = {a[5:2], ord ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
        for (int i = 0; i < 7; i++)
        begin
            // Advances carry flipped address, select and enables, which must be ignored
            u_ctl.c(1'h0, i inside {[1:3]}, i == 0 ? a : ~a, i == 0 ? !w : w, b, i == 0 ? e : 3'h6,
                (i >= 2 && i < 6) ? d + 18'(i - 2) : ~d);
            // Beat k of a read stands in call k+2; call 6 sees the lanes idle again
            if (i >= 2)
            begin
                chk("oe", {18{!w && on && !de && i < 6}}, doe);
                if (!w && on && i < 6)
                    chk("data", exp_mem[q[i-2]], dout);
            end
        end
        for (int k = 0; k < 4 && w && on; k++)
        begin
            dk = d + 18'(k);
            exp_mem[q[k]] = {b[1] ? exp_mem[q[k]][17:9] : dk[17:9], b[0] ? exp_mem[q[k]][8:0] : dk[8:0]};
        end
        $display("burst done w %0d a %h", w, a);
    endtask
    task conclude;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Run takes about 85 cycles; a far longer span means a hang
    initial
    begin
        #20000;
        err_count++;
        conclude;
    end
    // Main sequence: linear, byte lanes, deselects, gating, output enable, interleaved
    initial
    begin
        srst = 1;
        ord = 0;
        de = 0;
        err_count = 0;
        cmp_count = 0;
        rst(1'h0);
        burst(1'h1, 6'h06, 2'h0, 18'h00101, EN);
        burst(1'h0, 6'h04, 2'h3, 18'h0, EN);
        burst(1'h1, 6'h05, 2'h2, 18'h3c0aa, EN);
        burst(1'h0, 6'h07, 2'h0, 18'h0, EN);
        burst(1'h1, 6'h04, 2'h0, 18'h2aaaa, 3'h6);
        burst(1'h1, 6'h04, 2'h0, 18'h2aaaa, 3'h0);
        burst(1'h1, 6'h04, 2'h0, 18'h2aaaa, 3'h3);
        burst(1'h1, 6'h04, 2'h3, 18'h2aaaa, EN);
        u_ctl.c(1'h1, 1'h0, 6'h04, 1'h0, 2'h0, EN, 18'h0);
        de = 1;
        burst(1'h0, 6'h04, 2'h0, 18'h0, EN);
        de = 0;
        rst(1'h1);
        burst(1'h1, 6'h09, 2'h0, 18'h15511, EN);
        burst(1'h0, 6'h0a, 2'h0, 18'h0, EN);
        conclude;
    end
endmodule
`default_nettype wire
